// *** core/scrb_map.svh ***
// Purpose: constants for the synthesizer control register bank
// Assumes: 32-bit words, select code in bits 3:0
// Notes: offsets are byte addresses on the apb side
`ifndef SCRB_MAP_SVH
`define SCRB_MAP_SVH
`define SCRB_SEL_MAIN 4'h0
`define SCRB_SEL_AUX 4'h2
`define SCRB_SEL_PHASE 4'h3
`define SCRB_SEL_REFCFG 4'h4
`define SCRB_SEL_FIXED 4'h5
`define SCRB_SEL_OUTBLD 4'h6
`define SCRB_AUX_FRAC_LSB 18
`define SCRB_AUX_MOD_LSB 4
`define SCRB_PH_SDDIS 30
`define SCRB_PH_RESYNC 29
`define SCRB_PH_ADJ 28
`define SCRB_PH_VAL_LSB 4
`define SCRB_RC_MUX_LSB 27
`define SCRB_RC_DBL 26
`define SCRB_RC_HALF 25
`define SCRB_RC_RCNT_LSB 15
`define SCRB_RC_DBUF 14
`define SCRB_RC_CP_LSB 10
`define SCRB_RC_MUXLVL 8
`define SCRB_RC_POL 7
`define SCRB_RC_PD 6
`define SCRB_RC_TRI 5
`define SCRB_RC_CRST 4
`define SCRB_OB_BPOL 31
`define SCRB_OB_GATED 30
`define SCRB_OB_FBSEL 24
`define SCRB_OB_DIV_LSB 21
`define SCRB_FIXED_WORD 32'h00800025
`define SCRB_ADDR_DATA 8'h00
`define SCRB_ADDR_STATUS 8'h04
`define SCRB_ADDR_CFG 8'h08
`define SCRB_ADDR_PHASE 8'h0C
`define SCRB_ADDR_AUXF 8'h10
`define SCRB_ADDR_AUXM 8'h14
`endif

// *** core/scrb_pkg.sv ***
// Purpose: types for the synthesizer control register bank
// Assumes: nothing
// Notes: host sequencer states
package scrb_pkg;
  typedef enum logic [1:0] {SCRB_IDLE = 2'b01, SCRB_SEND = 2'b10} scrb_state_type;
endpackage

// *** core/scrb_link_if.sv ***
// Purpose: word link from host controller to register bank
// Assumes: same clock both ends
// Notes: one strobe per word
`timescale 1ns/1ps
interface scrb_link_if;
  logic [31:0] word;
  logic strobe;
  logic lock_detect;
  modport host (output word, output strobe, input lock_detect);
  modport dev (input word, input strobe, output lock_detect);
endinterface

// *** core/scrb_device.sv ***
// Purpose: synthesizer control register bank, device end
// Assumes: words arrive as one-cycle strobes on clk_i
// Notes: analog effects appear as control outputs
`timescale 1ns/1ps
`include "scrb_map.svh"
// Summary of operation
// - aux fraction = high times 2^14 plus low
// - host keeps aux fraction below modulus
// - aux modulus = high times 2^14 plus low
// - low four bits select destination register
// - host writes reserved top bits as zero
// - main write resets modulator unless disabled
// - resync needs enable, reset on, divided feedback; here the resync bit alone (adjust clear) loads the phase on main write
// - phase offset is value over 2^24 turns
// - phase adjust advances phase per main write
// - continual adjust: calibration off, reset disabled; here the adjust add on each main write ignores the reset-disable bit
// - test mux select; no dividers during retune
// - doubler bit selects doubling and active edges
// - halving bit adds divide-by-two toggle stage
// - ten-bit reference counter divides 1 to 1023
// - double buffer defers divider select to main
// - four-bit field selects pump current
// - polarity bit: 1 positive, 0 negative
// - power-down disables outputs, registers stay live
// - three-state bit floats the pump output
// - counter reset bit holds counters in reset
// - host loads fixed register with constant word
// - gated bleed waits for lock; top bit polarity
module scrb_device
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // link
  scrb_link_if.dev link,
  // synthesizer state
  input wire logic lock_raw_i,
  input wire logic ref_edge_i,
  // decoded controls
  output logic [37:0] aux_fraction_total_o,
  output logic [37:0] aux_modulus_total_o,
  output logic [23:0] phase_value_o,
  output logic [23:0] phase_accum_o,
  output logic modulator_reset_o,
  output logic resync_enable_o,
  output logic [2:0] test_mux_output_o,
  output logic [3:0] pump_current_select_o,
  output logic detector_polarity_o,
  output logic mux_logic_level_o,
  output logic pump_hiz_o,
  output logic counter_hold_o,
  output logic outputs_enable_o,
  output logic [2:0] rf_div_active_o,
  output logic feedback_select_o,
  output logic bleed_on_o,
  output logic bleed_polarity_o,
  output logic pfd_ref_o,
  output logic fixed_ok_o
);
  logic [31:0] aux_r, phase_r, refcfg_r, outbld_r, fixed_r;
  logic [13:0] frac_hi_r, mod_hi_r;
  logic [23:0] accum_r;
  logic [2:0] div_act_r;
  logic sdrst_r, lock_s1_r, lock_s2_r, ref_s1_r, ref_s2_r, ref_d_r, tog_r, pfd_r;
  logic [9:0] rcnt_r;
  wire [3:0] register_select_code = link.word[3:0];
  wire wr_main = link.strobe && register_select_code == `SCRB_SEL_MAIN;
  wire wr_aux = link.strobe && register_select_code == `SCRB_SEL_AUX;
  wire wr_ph = link.strobe && register_select_code == `SCRB_SEL_PHASE;
  wire wr_rc = link.strobe && register_select_code == `SCRB_SEL_REFCFG;
  wire wr_fx = link.strobe && register_select_code == `SCRB_SEL_FIXED;
  wire wr_ob = link.strobe && register_select_code == `SCRB_SEL_OUTBLD;
  wire wr_hi = link.strobe && register_select_code == 4'hD;
  wire power_down_bit = refcfg_r[`SCRB_RC_PD];
  wire counter_reset_bit = refcfg_r[`SCRB_RC_CRST];
  wire double_buffer_enable = refcfg_r[`SCRB_RC_DBUF];
  wire [9:0] rdiv = refcfg_r[`SCRB_RC_RCNT_LSB +: 10];
  wire lock_ok = lock_s2_r && !power_down_bit;
  wire ref_act = refcfg_r[`SCRB_RC_DBL] ? (ref_s2_r != ref_d_r) : (ref_d_r && !ref_s2_r);
  wire cnt_hold = counter_reset_bit || power_down_bit;
  wire rcnt_wrap = rcnt_r >= rdiv - 10'h001 || rdiv == 10'h000;
  // registers; unmatched codes store nothing
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      aux_r <= 32'h0; phase_r <= 32'h0; refcfg_r <= 32'h0; outbld_r <= 32'h0;
      fixed_r <= 32'h0; frac_hi_r <= 14'h0; mod_hi_r <= 14'h0;
    end
    else
    begin
      if (wr_aux) aux_r <= link.word;
      if (wr_ph) phase_r <= link.word;
      if (wr_rc) refcfg_r <= link.word;
      if (wr_ob) outbld_r <= link.word;
      if (wr_fx) fixed_r <= link.word;
      if (wr_hi) frac_hi_r <= link.word[31:18];
      if (wr_hi) mod_hi_r <= link.word[17:4];
    end
  end
  // main-write side effects
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      accum_r <= 24'h0; div_act_r <= 3'h0; sdrst_r <= 1'b0;
    end
    else
    begin
      sdrst_r <= wr_main && !phase_r[`SCRB_PH_SDDIS];
      if (wr_main && phase_r[`SCRB_PH_ADJ])
        accum_r <= accum_r + phase_r[`SCRB_PH_VAL_LSB +: 24];
      else if (wr_main && phase_r[`SCRB_PH_RESYNC])
        accum_r <= phase_r[`SCRB_PH_VAL_LSB +: 24];
      if (wr_main || !double_buffer_enable)
        div_act_r <= outbld_r[`SCRB_OB_DIV_LSB +: 3];
    end
  end
  // reference path: sync, divide, optional halving
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      lock_s1_r <= 1'b0; lock_s2_r <= 1'b0; ref_s1_r <= 1'b0; ref_s2_r <= 1'b0;
      ref_d_r <= 1'b0; rcnt_r <= 10'h0; tog_r <= 1'b0; pfd_r <= 1'b0;
    end
    else
    begin
      lock_s1_r <= lock_raw_i; lock_s2_r <= lock_s1_r;
      ref_s1_r <= ref_edge_i; ref_s2_r <= ref_s1_r; ref_d_r <= ref_s2_r;
      pfd_r <= 1'b0;
      if (cnt_hold)
      begin
        rcnt_r <= 10'h0; tog_r <= 1'b0;
      end
      else if (ref_act)
      begin
        rcnt_r <= rcnt_wrap ? 10'h0 : rcnt_r + 10'h001;
        if (rcnt_wrap)
        begin
          tog_r <= !tog_r;
          pfd_r <= refcfg_r[`SCRB_RC_HALF] ? !tog_r : 1'b1;
        end
      end
    end
  end
  assign aux_fraction_total_o = {frac_hi_r, 24'h0} >> 10 | {24'h0, aux_r[`SCRB_AUX_FRAC_LSB +: 14]};
  assign aux_modulus_total_o = {mod_hi_r, 24'h0} >> 10 | {24'h0, aux_r[`SCRB_AUX_MOD_LSB +: 14]};
  assign phase_value_o = phase_r[`SCRB_PH_VAL_LSB +: 24];
  assign phase_accum_o = accum_r;
  assign modulator_reset_o = sdrst_r;
  assign resync_enable_o = phase_r[`SCRB_PH_RESYNC];
  assign test_mux_output_o = refcfg_r[`SCRB_RC_MUX_LSB +: 3];
  assign pump_current_select_o = refcfg_r[`SCRB_RC_CP_LSB +: 4];
  assign detector_polarity_o = refcfg_r[`SCRB_RC_POL];
  assign mux_logic_level_o = refcfg_r[`SCRB_RC_MUXLVL];
  assign pump_hiz_o = refcfg_r[`SCRB_RC_TRI] || power_down_bit;
  assign counter_hold_o = cnt_hold;
  assign outputs_enable_o = !power_down_bit;
  assign rf_div_active_o = div_act_r;
  assign feedback_select_o = outbld_r[`SCRB_OB_FBSEL];
  assign bleed_on_o = !outbld_r[`SCRB_OB_GATED] || lock_ok;
  assign bleed_polarity_o = outbld_r[`SCRB_OB_BPOL];
  assign pfd_ref_o = pfd_r;
  assign fixed_ok_o = fixed_r == `SCRB_FIXED_WORD;
  assign link.lock_detect = lock_ok;
endmodule

// *** core/scrb_host.sv ***
// Purpose: host controller sending configuration words, apb slave
// Assumes: software keeps reserved bits and ordering legal
// Notes: write to data address sends one word
`timescale 1ns/1ps
`include "scrb_map.svh"
module scrb_host
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  scrb_link_if.host link
);
  scrb_pkg::scrb_state_type state_r;
  logic [31:0] word_r, last_r;
  wire acc = psel && penable;
  wire send = acc && pwrite && paddr == `SCRB_ADDR_DATA;
  wire known = paddr == `SCRB_ADDR_DATA || paddr == `SCRB_ADDR_STATUS;
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_r <= scrb_pkg::SCRB_IDLE; word_r <= 32'h0; last_r <= 32'h0;
    end
    else
    begin
      case (state_r)
        scrb_pkg::SCRB_IDLE:
          if (send)
          begin
            word_r <= pwdata; last_r <= pwdata; state_r <= scrb_pkg::SCRB_SEND;
          end
        scrb_pkg::SCRB_SEND:
          state_r <= scrb_pkg::SCRB_IDLE;
        default:
          state_r <= scrb_pkg::SCRB_IDLE;
      endcase
    end
  end
  // reserved bits are software's duty
  assign link.word = word_r;
  assign link.strobe = state_r == scrb_pkg::SCRB_SEND;
  assign pready = 1'b1;
  assign pslverr = acc && !known;
  assign prdata = paddr == `SCRB_ADDR_STATUS ? {30'h0, link.lock_detect, state_r == scrb_pkg::SCRB_SEND} : last_r;
endmodule

// *** tb/scrb_sva.sv ***
// Purpose: link and control checks for the register bank
// Assumes: a strobed word takes effect one edge later
// Notes: keeps shadow copies of written words
`timescale 1ns/1ps
module scrb_sva
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // link and controls
  input wire logic [31:0] word,
  input wire logic strobe,
  input wire logic lock_detect,
  input wire logic modulator_reset_o,
  input wire logic pump_hiz_o,
  input wire logic [2:0] rf_div_active_o,
  input wire logic bleed_on_o
);
  logic [31:0] ph_r, cfg_r, ob_r;
  wire logic main_w = strobe && word[3:0] == 4'h0;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  always_ff @(posedge clk_i)
  begin
    ph_r <= reset_i ? 32'h00000000 : (strobe && word[3:0] == 4'h3) ? word : ph_r;
    cfg_r <= reset_i ? 32'h00000000 : (strobe && word[3:0] == 4'h4) ? word : cfg_r;
    ob_r <= reset_i ? 32'h00000000 : (strobe && word[3:0] == 4'h6) ? word : ob_r;
  end
  property p_pulse; strobe |=> !strobe; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
  property p_hold; $changed(word) |-> strobe; endproperty
  a_hold: assert property (p_hold) else $error("word changed without strobe");
  property p_first; $past(reset_i) |-> !strobe; endproperty
  a_first: assert property (p_first) else $error("strobe right after reset");
  property p_mod; main_w |=> modulator_reset_o == !ph_r[30]; endproperty
  a_mod: assert property (p_mod) else $error("modulator reset wrong after main write");
  property p_mod_cause; modulator_reset_o |-> $past(main_w); endproperty
  a_mod_cause: assert property (p_mod_cause) else $error("modulator reset without main write");
  property p_hiz; pump_hiz_o == (cfg_r[5] || cfg_r[6]); endproperty
  a_hiz: assert property (p_hiz) else $error("pump high impedance wrong");
  property p_buf; strobe && word[3:0] == 4'h6 && cfg_r[14] |=> $stable(rf_div_active_o); endproperty
  a_buf: assert property (p_buf) else $error("divider select not deferred");
  property p_bleed; ob_r[30] && !lock_detect |-> !bleed_on_o; endproperty
  a_bleed: assert property (p_bleed) else $error("bleed on before lock");
  c_main: cover property (main_w && !ph_r[30]);
  c_adj: cover property (main_w && ph_r[28]);
  c_buf: cover property (strobe && word[3:0] == 4'h6 && cfg_r[14]);
endmodule

// *** tb/synth_control_register_bank_test.sv ***
// Purpose: bench joining host and device ends
// Assumes: apb slave answers without wait states
// Notes: each task checks its own outcome
`timescale 1ns/1ps
module synth_control_register_bank_test;
  logic clk_i = 1'b0, reset_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lock_raw_i = 1'b0, er;
  logic ref_edge_i = 1'b0, pfd_ref_o, counter_hold_o;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [37:0] aux_fraction_total_o, aux_modulus_total_o;
  logic [23:0] phase_value_o, phase_accum_o;
  logic [3:0] pump_current_select_o;
  logic [2:0] test_mux_output_o, rf_div_active_o;
  logic pready, pslverr, modulator_reset_o, detector_polarity_o, pump_hiz_o, outputs_enable_o, bleed_on_o;
  int mismatches = 0, samples_checked = 0;
  scrb_link_if link();
  always #25 clk_i = ~clk_i;
  scrb_host u_scrb_host (.clk_i, .reset_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .link(link));
  scrb_device u_scrb_device (.clk_i, .reset_i, .link(link), .lock_raw_i, .ref_edge_i, .aux_fraction_total_o,
    .aux_modulus_total_o, .phase_value_o, .phase_accum_o, .modulator_reset_o, .resync_enable_o(), .test_mux_output_o,
    .pump_current_select_o, .detector_polarity_o, .mux_logic_level_o(), .pump_hiz_o, .counter_hold_o,
    .outputs_enable_o, .rf_div_active_o, .feedback_select_o(), .bleed_on_o, .bleed_polarity_o(), .pfd_ref_o,
    .fixed_ok_o());
  scrb_sva u_scrb_sva (.clk_i, .reset_i, .word(link.word), .strobe(link.strobe), .lock_detect(link.lock_detect),
    .modulator_reset_o, .pump_hiz_o, .rf_div_active_o, .bleed_on_o);
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] w);
    int n;
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, w};
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    for (n = 0; n < 50 && pready !== 1'b1; n++)
      @(posedge clk_i);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    check(n == 50, 1'b0);
    if (n == 50)
      print_verdict();
    repeat (4) @(posedge clk_i);
  endtask
  task automatic t_aux();
    apb(1'b1, 8'h00, 32'h00141002);
    apb(1'b1, 8'h00, 32'h000C007D);
    check(aux_fraction_total_o, 38'h000000C005);
    check(aux_modulus_total_o, 38'h000001C100);
  endtask
  task automatic t_phase();
    apb(1'b1, 8'h00, 32'h01234563);
    apb(1'b1, 8'h00, 32'h00000000);
    check(phase_value_o, 24'h123456);
    apb(1'b1, 8'h00, 32'h20ABCDE3);
    apb(1'b1, 8'h00, 32'h00000000);
    check(phase_accum_o, 24'h0ABCDE);
    apb(1'b1, 8'h00, 32'h51234563);
    apb(1'b1, 8'h00, 32'h00000000);
    check(phase_accum_o, 24'h1CF134);
  endtask
  task automatic ref_run(input logic [31:0] w, input int exp);
    int p;
    p = 0;
    apb(1'b1, 8'h00, w);
    repeat (6)
    begin
      ref_edge_i <= 1'b1;
      repeat (4)
      begin
        @(posedge clk_i);
        p += pfd_ref_o;
      end
      ref_edge_i <= 1'b0;
      repeat (4)
      begin
        @(posedge clk_i);
        p += pfd_ref_o;
      end
    end
    check(p, exp);
  endtask
  task automatic t_refpath();
    ref_run(32'h00018004, 2);
    ref_run(32'h02018004, 1);
    ref_run(32'h04018004, 4);
    ref_run(32'h00018014, 0);
    check(counter_hold_o, 1'b1);
  endtask
  task automatic t_refcfg();
    apb(1'b1, 8'h00, 32'h280024B4);
    check({test_mux_output_o, pump_current_select_o}, 7'h59);
    check({detector_polarity_o, pump_hiz_o}, 2'h3);
    apb(1'b1, 8'h00, 32'h00000044);
    check({outputs_enable_o, pump_hiz_o, detector_polarity_o}, 3'h2);
    apb(1'b1, 8'h00, 32'h00003C07);
    check(pump_current_select_o, 4'h0);
  endtask
  task automatic t_buffer();
    apb(1'b1, 8'h00, 32'h00004004);
    apb(1'b1, 8'h00, 32'hC0A00006);
    check({rf_div_active_o, bleed_on_o}, 4'h0);
    apb(1'b1, 8'h00, 32'h00000000);
    check(rf_div_active_o, 3'h5);
    lock_raw_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    apb(1'b0, 8'h04, 32'h00000000);
    check(rd[1], 1'b1);
    apb(1'b0, 8'h40, 32'h00000000);
    check(er, 1'b1);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_aux();
    t_phase();
    t_refcfg();
    t_buffer();
    t_refpath();
    print_verdict();
  end
endmodule
